// ===== verilog/rcm_pkg.sv
/*
  Constants, field layout and types for one event channel input selector.
  Assumes a single 20 MHz peripheral clock and an Avalon-MM register port.
*/
package rcm_pkg;

  // Register byte offsets
  localparam logic [3:0] CTRL_OFS  = 4'h0;
  localparam logic [3:0] VALUE_OFS = 4'h4;

  // Control register field positions
  localparam int SIG_POS      = 0;
  localparam int SRC_POS      = 8;
  localparam int EDGE_FLD_POS = 20;

  // Values after reset
  localparam logic [6:0]  SRC_RST  = 7'h00;
  localparam logic [2:0]  SIG_RST  = 3'h0;
  localparam logic [31:0] RDATA_RST = 32'h0000_0000;

  // Synchroniser width for asynchronous sources
  localparam int ASYNC_W = 26;

  // Source select codes
  localparam logic [6:0] SRC_NONE   = 7'h00;
  localparam logic [6:0] SRC_PINS_H = 7'h0d;
  localparam logic [6:0] SRC_LPTIM  = 7'h0e;
  localparam logic [6:0] SRC_PCNT0  = 7'h0f;
  localparam logic [6:0] SRC_PCNT1  = 7'h10;
  localparam logic [6:0] SRC_PCNT2  = 7'h11;
  localparam logic [6:0] SRC_CLKMGT = 7'h12;
  localparam logic [6:0] SRC_DAC    = 7'h18;
  localparam logic [6:0] SRC_ULTIM  = 7'h1a;
  localparam logic [6:0] SRC_SER0   = 7'h30;
  localparam logic [6:0] SRC_SER1   = 7'h31;
  localparam logic [6:0] SRC_SER2   = 7'h32;
  localparam logic [6:0] SRC_SER3   = 7'h33;
  localparam logic [6:0] SRC_TIM0   = 7'h3c;
  localparam logic [6:0] SRC_TIM1   = 7'h3d;
  localparam logic [6:0] SRC_WTIM0  = 7'h3e;
  localparam logic [6:0] SRC_WTIM1  = 7'h3f;

  // Edge detection choice
  typedef enum logic [1:0] {
    EDGE_OFF  = 2'b00,
    EDGE_POS  = 2'b01,
    EDGE_NEG  = 2'b10,
    EDGE_BOTH = 2'b11
  } rcm_edge_t;

  localparam rcm_edge_t EDGE_RST = EDGE_OFF;

endpackage

// ===== verilog/rcm_sync.sv
/*
  Three-stage synchroniser with agreement filter for a vector of levels.
  Assumes inputs are asynchronous to CLK_I; output is registered.
*/
`timescale 1ns/10ps
module rcm_sync #(
  parameter int WIDTH = rcm_pkg::ASYNC_W
) (
  input  wire logic             clk_i,
  input  wire logic             reset_n_i,
  input  wire logic [WIDTH-1:0] async_i,
  output logic      [WIDTH-1:0] sync_o
);

  typedef struct packed {
    logic [WIDTH-1:0] s1;
    logic [WIDTH-1:0] s2;
    logic [WIDTH-1:0] s3;
    logic [WIDTH-1:0] stable;
  } rcm_sync_st_t;

  rcm_sync_st_t st_ff;
  rcm_sync_st_t nxt_st;

  ////////////////////////////////////////////////////////////////////////
  // Chain; a bit changes only once stages two and three agree
  always_comb begin
    nxt_st    = st_ff;
    nxt_st.s1 = async_i;
    nxt_st.s2 = st_ff.s1;
    nxt_st.s3 = st_ff.s2;
    for (int i = 0; i < WIDTH; i++) begin
      if (st_ff.s2[i] == st_ff.s3[i]) begin
        nxt_st.stable[i] = st_ff.s3[i];
      end
    end
  end

  // State register
  always_ff @(posedge clk_i or negedge reset_n_i) begin
    if (!reset_n_i) begin
      st_ff <= '0;
    end else begin
      st_ff <= nxt_st;
    end
  end

  assign sync_o = st_ff.stable;

endmodule

// ===== verilog/rcm_edge.sv
/*
  Edge detector for the selected channel level.
  Assumes level_i is already on CLK_I; pulse output is registered.
*/
`timescale 1ns/10ps
module rcm_edge (
  input  wire logic              clk_i,
  input  wire logic              reset_n_i,
  input  wire logic              level_i,
  input  rcm_pkg::rcm_edge_t     mode_i,
  output logic                   out_o
);

  typedef struct packed {
    logic prev;
    logic out;
  } rcm_edge_st_t;

  rcm_edge_st_t st_ff;
  rcm_edge_st_t nxt_st;

  ////////////////////////////////////////////////////////////////////////
  // Pass level or form one-cycle pulses per chosen edge
  always_comb begin
    nxt_st      = st_ff;
    nxt_st.prev = level_i;
    case (mode_i)
      rcm_pkg::EDGE_OFF:  nxt_st.out = level_i;
      rcm_pkg::EDGE_POS:  nxt_st.out = level_i & ~st_ff.prev;
      rcm_pkg::EDGE_NEG:  nxt_st.out = ~level_i & st_ff.prev;
      rcm_pkg::EDGE_BOTH: nxt_st.out = level_i ^ st_ff.prev;
      default:            nxt_st.out = 1'b0;
    endcase
  end

  // State register
  always_ff @(posedge clk_i or negedge reset_n_i) begin
    if (!reset_n_i) begin
      st_ff <= '0;
    end else begin
      st_ff <= nxt_st;
    end
  end

  assign out_o = st_ff.out;

endmodule

// ===== verilog/rcm_channel_mux.sv
/*
  Input selection multiplexer for one event routing channel, upper
  source codes, with an Avalon-MM control/status register port.
  Asynchronous producers reach CHANNEL_INPUT_O five edges after a change,
  synchronous ones one edge after; a selection change may give one pulse.
  Assumes producers on CLK_I except those routed through the synchroniser.
  Assumes a master that holds each request until it sees waitrequest low;
  writes land at that completing edge.
*/
`timescale 1ns/10ps
module rcm_channel_mux (
  input  wire logic        CLK_I,
  input  wire logic        RESET_N_I,
  // Avalon-MM slave
  input  wire logic [3:0]  AVS_ADDRESS_I,
  input  wire logic        AVS_READ_I,
  input  wire logic        AVS_WRITE_I,
  input  wire logic [3:0]  AVS_BYTEENABLE_I,
  input  wire logic [31:0] AVS_WRITEDATA_I,
  output logic      [31:0] AVS_READDATA_O,
  output logic             AVS_WAITREQUEST_O,
  // Asynchronous producers
  input  wire logic [7:0]  UPPER_PIN_GROUP_I,
  input  wire logic [1:0]  LOWPOWER_TIMER_OUT_I,
  input  wire logic [2:0]  PULSE_COUNTER_COMPARE_MATCH_I,
  input  wire logic [2:0]  PULSE_COUNTER_WRAP_I,
  input  wire logic [2:0]  PULSE_COUNTER_DIRECTION_I,
  input  wire logic [1:0]  CLOCK_OUTPUT_I,
  input  wire logic [2:0]  OPAMP_WARMED_I,
  input  wire logic [2:0]  OPAMP_VALID_I,
  input  wire logic [2:0]  OPAMP_STATUS_SELECT_I,
  input  wire logic        ULTRALOW_TIMER_PERIOD_I,
  // Producers on CLK_I (infrared bit 1 is asynchronous)
  input  wire logic [1:0]  DAC_CHANNEL_DONE_I,
  input  wire logic [1:0]  SERIAL_INFRARED_OUT_I,
  input  wire logic [3:0]  SERIAL_TRANSMIT_COMPLETE_I,
  input  wire logic [3:0]  SERIAL_RECEIVE_VALID_I,
  input  wire logic [3:0]  SERIAL_RTS_I,
  input  wire logic [3:0]  SERIAL_TX_I,
  input  wire logic [3:0]  SERIAL_CS_I,
  input  wire logic [1:0]  TIMER_UNDERFLOW_I,
  input  wire logic [1:0]  TIMER_OVERFLOW_I,
  input  wire logic [7:0]  TIMER_COMPARE_CAPTURE_I,
  input  wire logic [1:0]  WIDE_TIMER_UNDERFLOW_I,
  input  wire logic [1:0]  WIDE_TIMER_OVERFLOW_I,
  input  wire logic [7:0]  WIDE_TIMER_COMPARE_CAPTURE_I,
  // Channel
  output logic             CHANNEL_INPUT_O,
  output logic             CHANNEL_OUTPUT_O
);

  typedef struct packed {
    logic [6:0]         source_select;
    logic [2:0]         signal_select;
    rcm_pkg::rcm_edge_t edge_detect_choice;
    logic               waitreq;
    logic [31:0]        rdata;
    logic               level;
  } rcm_mux_st_t;

  rcm_mux_st_t st_ff;
  rcm_mux_st_t nxt_st;

  // Synchroniser input and output; op-amp status is chosen ahead of it
  logic [rcm_pkg::ASYNC_W-1:0] async_raw;
  logic [rcm_pkg::ASYNC_W-1:0] async_sync;
  logic [2:0]                  opamp_raw;

  // Synchronised producer groups, one slice each
  logic [7:0]                  pins_s;
  logic [1:0]                  lptim_s;
  logic [2:0]                  pc_cmp_s;
  logic [2:0]                  pc_wrap_s;
  logic [2:0]                  pc_dir_s;
  logic [1:0]                  clk_s;
  logic [2:0]                  opamp_s;
  logic                        ultim_s;
  logic                        irda2_s;

  // Edge stage output and bus handshake terms
  logic                        chan_out;
  logic                        req;
  logic                        take;
  logic                        done;

  ////////////////////////////////////////////////////////////////////////
  // Signal decode shared by the four serial ports
  function automatic logic sel_serial(
    input logic       has_irda,
    input logic       irda,
    input logic       txc,
    input logic       rxv,
    input logic       rts,
    input logic       tx,
    input logic       cs,
    input logic [2:0] sig
  );
    logic r;
    r = 1'b0;
    case (sig)
      3'h0:    r = has_irda & irda;
      3'h1:    r = txc;
      3'h2:    r = rxv;
      3'h3:    r = rts;
      3'h5:    r = tx;
      3'h6:    r = cs;
      default: r = 1'b0;
    endcase
    return r;
  endfunction

  // Signal decode shared by the four timers
  function automatic logic sel_timer(
    input logic       has_cc3,
    input logic       uf,
    input logic       of,
    input logic [3:0] cc,
    input logic [2:0] sig
  );
    logic r;
    r = 1'b0;
    case (sig)
      3'h0:    r = uf;
      3'h1:    r = of;
      3'h2:    r = cc[0];
      3'h3:    r = cc[1];
      3'h4:    r = cc[2];
      3'h5:    r = has_cc3 & cc[3];
      default: r = 1'b0;
    endcase
    return r;
  endfunction

  // Low bits pick from a small group, out of range gives low
  function automatic logic sel_group(
    input logic [7:0] grp,
    input logic [3:0] count,
    input logic [2:0] sig
  );
    return ({1'b0, sig} < count) ? grp[sig] : 1'b0;
  endfunction

  ////////////////////////////////////////////////////////////////////////
  // Op-amp status chosen by each amplifier's mode, then synchronised
  always_comb begin
    for (int i = 0; i < 3; i++) begin
      opamp_raw[i] = OPAMP_STATUS_SELECT_I[i] ? OPAMP_VALID_I[i] : OPAMP_WARMED_I[i];
    end
  end

  // Asynchronous sources gathered for the synchroniser
  assign async_raw = {SERIAL_INFRARED_OUT_I[1], ULTRALOW_TIMER_PERIOD_I, opamp_raw,
                      CLOCK_OUTPUT_I, PULSE_COUNTER_DIRECTION_I, PULSE_COUNTER_WRAP_I,
                      PULSE_COUNTER_COMPARE_MATCH_I, LOWPOWER_TIMER_OUT_I,
                      UPPER_PIN_GROUP_I};

  rcm_sync #(
    .WIDTH (rcm_pkg::ASYNC_W)
  ) u_sync (
    .clk_i     (CLK_I),
    .reset_n_i (RESET_N_I),
    .async_i   (async_raw),
    .sync_o    (async_sync)
  );

  // Synchronised slices
  assign pins_s    = async_sync[7:0];
  assign lptim_s   = async_sync[9:8];
  assign pc_cmp_s  = async_sync[12:10];
  assign pc_wrap_s = async_sync[15:13];
  assign pc_dir_s  = async_sync[18:16];
  assign clk_s     = async_sync[20:19];
  assign opamp_s   = async_sync[23:21];
  assign ultim_s   = async_sync[24];
  assign irda2_s   = async_sync[25];

  ////////////////////////////////////////////////////////////////////////
  // Bus handshake: request taken while waitrequest is high, completed at
  // the following edge, where waitrequest is seen low
  assign req  = AVS_READ_I | AVS_WRITE_I;
  assign take = req & st_ff.waitreq;
  assign done = AVS_WRITE_I & ~st_ff.waitreq;

  // Register access and channel selection
  always_comb begin
    nxt_st         = st_ff;
    nxt_st.waitreq = ~take;

    // Read data formed when taken, so it stands at the completing edge
    if (take) begin
      nxt_st.rdata = rcm_pkg::RDATA_RST;
      if (AVS_READ_I && AVS_ADDRESS_I == rcm_pkg::CTRL_OFS) begin
        nxt_st.rdata = {10'h000, st_ff.edge_detect_choice, 5'h00,
                        st_ff.source_select, 5'h00, st_ff.signal_select};
      end else if (AVS_READ_I && AVS_ADDRESS_I == rcm_pkg::VALUE_OFS) begin
        nxt_st.rdata = {30'h0000_0000, chan_out, st_ff.level};
      end
    end

    // A write lands only at the edge that completes it, never while waiting;
    // the value word and unmapped places ignore writes
    if (done && AVS_ADDRESS_I == rcm_pkg::CTRL_OFS) begin
      if (AVS_BYTEENABLE_I[0]) begin
        nxt_st.signal_select = AVS_WRITEDATA_I[rcm_pkg::SIG_POS +: 3];
      end
      if (AVS_BYTEENABLE_I[1]) begin
        nxt_st.source_select = AVS_WRITEDATA_I[rcm_pkg::SRC_POS +: 7];
      end
      if (AVS_BYTEENABLE_I[2]) begin
        nxt_st.edge_detect_choice = rcm_pkg::rcm_edge_t'(AVS_WRITEDATA_I[rcm_pkg::EDGE_FLD_POS +: 2]);
      end
    end

    // Source and signal decode
    // Asynchronous groups read synchronised copies; the rest is on CLK_I already
    case (st_ff.source_select)
      rcm_pkg::SRC_NONE:
        nxt_st.level = 1'b0;
      rcm_pkg::SRC_PINS_H:
        nxt_st.level = pins_s[st_ff.signal_select];
      rcm_pkg::SRC_LPTIM:
        nxt_st.level = sel_group({6'h00, lptim_s}, 4'h2, st_ff.signal_select);
      rcm_pkg::SRC_PCNT0:
        nxt_st.level = sel_group({5'h00, pc_dir_s[0], pc_wrap_s[0], pc_cmp_s[0]},
                                 4'h3, st_ff.signal_select);
      rcm_pkg::SRC_PCNT1:
        nxt_st.level = sel_group({5'h00, pc_dir_s[1], pc_wrap_s[1], pc_cmp_s[1]},
                                 4'h3, st_ff.signal_select);
      rcm_pkg::SRC_PCNT2:
        nxt_st.level = sel_group({5'h00, pc_dir_s[2], pc_wrap_s[2], pc_cmp_s[2]},
                                 4'h3, st_ff.signal_select);
      rcm_pkg::SRC_CLKMGT:
        nxt_st.level = sel_group({6'h00, clk_s}, 4'h2, st_ff.signal_select);
      rcm_pkg::SRC_DAC:
        nxt_st.level = sel_group({3'h0, opamp_s, DAC_CHANNEL_DONE_I},
                                 4'h5, st_ff.signal_select);
      rcm_pkg::SRC_ULTIM:
        nxt_st.level = sel_group({7'h00, ultim_s}, 4'h1, st_ff.signal_select);
      rcm_pkg::SRC_SER0:
        nxt_st.level = sel_serial(1'b1, SERIAL_INFRARED_OUT_I[0], SERIAL_TRANSMIT_COMPLETE_I[0],
                                  SERIAL_RECEIVE_VALID_I[0], SERIAL_RTS_I[0], SERIAL_TX_I[0],
                                  SERIAL_CS_I[0], st_ff.signal_select);
      rcm_pkg::SRC_SER1:
        nxt_st.level = sel_serial(1'b0, 1'b0, SERIAL_TRANSMIT_COMPLETE_I[1],
                                  SERIAL_RECEIVE_VALID_I[1], SERIAL_RTS_I[1], SERIAL_TX_I[1],
                                  SERIAL_CS_I[1], st_ff.signal_select);
      rcm_pkg::SRC_SER2:
        nxt_st.level = sel_serial(1'b1, irda2_s, SERIAL_TRANSMIT_COMPLETE_I[2],
                                  SERIAL_RECEIVE_VALID_I[2], SERIAL_RTS_I[2], SERIAL_TX_I[2],
                                  SERIAL_CS_I[2], st_ff.signal_select);
      rcm_pkg::SRC_SER3:
        nxt_st.level = sel_serial(1'b0, 1'b0, SERIAL_TRANSMIT_COMPLETE_I[3],
                                  SERIAL_RECEIVE_VALID_I[3], SERIAL_RTS_I[3], SERIAL_TX_I[3],
                                  SERIAL_CS_I[3], st_ff.signal_select);
      rcm_pkg::SRC_TIM0:
        nxt_st.level = sel_timer(1'b0, TIMER_UNDERFLOW_I[0], TIMER_OVERFLOW_I[0],
                                 TIMER_COMPARE_CAPTURE_I[3:0], st_ff.signal_select);
      rcm_pkg::SRC_TIM1:
        nxt_st.level = sel_timer(1'b1, TIMER_UNDERFLOW_I[1], TIMER_OVERFLOW_I[1],
                                 TIMER_COMPARE_CAPTURE_I[7:4], st_ff.signal_select);
      rcm_pkg::SRC_WTIM0:
        nxt_st.level = sel_timer(1'b0, WIDE_TIMER_UNDERFLOW_I[0], WIDE_TIMER_OVERFLOW_I[0],
                                 WIDE_TIMER_COMPARE_CAPTURE_I[3:0], st_ff.signal_select);
      rcm_pkg::SRC_WTIM1:
        nxt_st.level = sel_timer(1'b1, WIDE_TIMER_UNDERFLOW_I[1], WIDE_TIMER_OVERFLOW_I[1],
                                 WIDE_TIMER_COMPARE_CAPTURE_I[7:4], st_ff.signal_select);
      default:
        nxt_st.level = 1'b0;
    endcase
  end

  ////////////////////////////////////////////////////////////////////////
  // State register
  always_ff @(posedge CLK_I or negedge RESET_N_I) begin
    if (!RESET_N_I) begin
      st_ff.source_select      <= rcm_pkg::SRC_RST;
      st_ff.signal_select      <= rcm_pkg::SIG_RST;
      st_ff.edge_detect_choice <= rcm_pkg::EDGE_RST;
      st_ff.waitreq            <= 1'b1;
      st_ff.rdata              <= rcm_pkg::RDATA_RST;
      st_ff.level              <= 1'b0;
    end else begin
      st_ff <= nxt_st;
    end
  end

  // Edge detect stage
  rcm_edge u_edge (
    .clk_i     (CLK_I),
    .reset_n_i (RESET_N_I),
    .level_i   (st_ff.level),
    .mode_i    (st_ff.edge_detect_choice),
    .out_o     (chan_out)
  );

  // Outputs straight from flip-flops
  assign AVS_READDATA_O    = st_ff.rdata;
  assign AVS_WAITREQUEST_O = st_ff.waitreq;
  assign CHANNEL_INPUT_O   = st_ff.level;
  assign CHANNEL_OUTPUT_O  = chan_out;

endmodule

// ===== sim/rcm_channel_mux_sva.sv
/*
  Checker for the channel selector: bus handshake, control shadow, selection and edge relations.
  Assumes it is bound to rcm_channel_mux and sees only its ports.
*/
`timescale 1ns/10ps
module rcm_channel_mux_sva (
  input wire logic        CLK_I,
  input wire logic        RESET_N_I,
  input wire logic [3:0]  AVS_ADDRESS_I,
  input wire logic        AVS_READ_I,
  input wire logic        AVS_WRITE_I,
  input wire logic [3:0]  AVS_BYTEENABLE_I,
  input wire logic [31:0] AVS_WRITEDATA_I,
  input wire logic [31:0] AVS_READDATA_O,
  input wire logic        AVS_WAITREQUEST_O,
  input wire logic        CHANNEL_INPUT_O,
  input wire logic        CHANNEL_OUTPUT_O
);
  logic [2:0] sig_ff;
  logic [6:0] src_ff;
  logic [1:0] edge_ff;
  logic [2:0] age_ff;
  logic       taken;
  logic       unasg;
  logic       ci;

  default clocking @(posedge CLK_I); endclocking
  default disable iff (!RESET_N_I);

  ////////////////////////////////////////
  // Request accepted, and listed codes that carry no signal
  assign taken = (AVS_READ_I || AVS_WRITE_I) && AVS_WAITREQUEST_O;
  assign unasg = ((src_ff == rcm_pkg::SRC_SER1 || src_ff == rcm_pkg::SRC_SER3) && sig_ff == 3'h0)
              || (src_ff[6:2] == 5'h0c && (sig_ff == 3'h4 || sig_ff == 3'h7))
              || ((src_ff == rcm_pkg::SRC_TIM0 || src_ff == rcm_pkg::SRC_WTIM0) && sig_ff > 3'h4);
  assign ci = CHANNEL_INPUT_O;

  // Shadow of the control word and cycles since it was last written
  always_ff @(posedge CLK_I or negedge RESET_N_I) begin
    if (!RESET_N_I) begin
      sig_ff  <= 3'h0;
      src_ff  <= 7'h00;
      edge_ff <= 2'h0;
      age_ff  <= 3'h0;
    end else if (AVS_WRITE_I && !AVS_WAITREQUEST_O && AVS_ADDRESS_I == rcm_pkg::CTRL_OFS) begin
      if (AVS_BYTEENABLE_I[0]) sig_ff <= AVS_WRITEDATA_I[2:0];
      if (AVS_BYTEENABLE_I[1]) src_ff <= AVS_WRITEDATA_I[14:8];
      if (AVS_BYTEENABLE_I[2]) edge_ff <= AVS_WRITEDATA_I[21:20];
      age_ff <= 3'h0;
    end else if (age_ff != 3'h7) begin
      age_ff <= age_ff + 3'h1;
    end
  end

  ////////////////////////////////////////
  sequence s_rd;
    taken && AVS_READ_I;
  endsequence
  sequence s_settled;
    age_ff > 3'h2;
  endsequence

  property p_wait_answer;
    taken |=> !AVS_WAITREQUEST_O;
  endproperty
  a_wait_answer: assert property (p_wait_answer) else $error("no answer after request");
  property p_wait_one;
    !AVS_WAITREQUEST_O |=> AVS_WAITREQUEST_O;
  endproperty
  a_wait_one: assert property (p_wait_one) else $error("waitrequest low too long");
  property p_ctrl_read;
    s_rd ##0 AVS_ADDRESS_I == rcm_pkg::CTRL_OFS |=> AVS_READDATA_O == {10'h0, edge_ff, 5'h0, src_ff, 5'h0, sig_ff};
  endproperty
  a_ctrl_read: assert property (p_ctrl_read) else $error("control readback wrong");
  property p_unmapped_read;
    s_rd ##0 AVS_ADDRESS_I != 4'h0 && AVS_ADDRESS_I != 4'h4 |=> AVS_READDATA_O == 32'h0;
  endproperty
  a_unmapped_read: assert property (p_unmapped_read) else $error("unmapped read not zero");
  property p_src_off;
    s_settled ##0 src_ff == rcm_pkg::SRC_NONE |-> !ci;
  endproperty
  a_src_off: assert property (p_src_off) else $error("input high with source off");
  property p_unasg;
    s_settled ##0 unasg |-> !ci;
  endproperty
  a_unasg: assert property (p_unasg) else $error("unassigned code not low");
  property p_level;
    s_settled ##0 edge_ff == rcm_pkg::EDGE_OFF |-> CHANNEL_OUTPUT_O == $past(ci);
  endproperty
  a_level: assert property (p_level) else $error("level mode output wrong");
  property p_rise;
    s_settled ##0 edge_ff == rcm_pkg::EDGE_POS |-> CHANNEL_OUTPUT_O == ($past(ci) && !$past(ci, 2));
  endproperty
  a_rise: assert property (p_rise) else $error("rising pulse wrong");
  property p_fall;
    s_settled ##0 edge_ff == rcm_pkg::EDGE_NEG |-> CHANNEL_OUTPUT_O == (!$past(ci) && $past(ci, 2));
  endproperty
  a_fall: assert property (p_fall) else $error("falling pulse wrong");
  property p_both;
    s_settled ##0 edge_ff == rcm_pkg::EDGE_BOTH |-> CHANNEL_OUTPUT_O == ($past(ci) != $past(ci, 2));
  endproperty
  a_both: assert property (p_both) else $error("both-edge pulse wrong");
endmodule

bind rcm_channel_mux rcm_channel_mux_sva u_sva (.CLK_I, .RESET_N_I, .AVS_ADDRESS_I, .AVS_READ_I,
  .AVS_WRITE_I, .AVS_BYTEENABLE_I, .AVS_WRITEDATA_I, .AVS_READDATA_O, .AVS_WAITREQUEST_O,
  .CHANNEL_INPUT_O, .CHANNEL_OUTPUT_O);

// ===== sim/rcm_producer_model.sv
/*
  Model of the peripheral outputs feeding the selector, as one flat level vector.
  Assumes the bench changes pick and invert just after a clock edge.
*/
`timescale 1ns/10ps
module rcm_producer_model (
  input  wire logic [6:0]  pick_i,
  input  wire logic        invert_i,
  output logic      [75:0] level_o
);
  ////////////////////////////////////////
  // All producers rest at the invert level; the picked one goes the other way
  always_comb begin
    level_o = {76{invert_i}};
    if (pick_i < 7'h4c) level_o[pick_i] = !invert_i;
  end
endmodule

// ===== sim/rcm_channel_mux_tb.sv
/*
  Self-checking bench for the channel selector: registers, full code map, edge modes.
  Assumes rcm_producer_model drives every producer input except OPAMP_STATUS_SELECT_I, which the bench drives.
*/
`timescale 1ns/10ps
module rcm_channel_mux_tb;
  logic        clk = 1'b0;
  logic        rst_n = 1'b0;
  logic [3:0]  addr = 4'h0;
  logic        rd = 1'b0;
  logic        wr = 1'b0;
  logic [3:0]  be = 4'h0;
  logic [31:0] wd = 32'h0;
  logic [31:0] rdata;
  logic        wreq;
  logic [2:0]  opsel = 3'h0;
  logic [6:0]  pick = 7'h7f;
  logic        inv = 1'b0;
  logic [75:0] v;
  logic        ch_in;
  logic        ch_out;
  int          fail_count = 0;
  int          checks = 0;

  // Clock at 50 ns
  always #25 clk = ~clk;

  rcm_producer_model u_model (.pick_i(pick), .invert_i(inv), .level_o(v));

  rcm_channel_mux u_dut (.CLK_I(clk), .RESET_N_I(rst_n), .AVS_ADDRESS_I(addr), .AVS_READ_I(rd),
    .AVS_WRITE_I(wr), .AVS_BYTEENABLE_I(be), .AVS_WRITEDATA_I(wd), .AVS_READDATA_O(rdata),
    .AVS_WAITREQUEST_O(wreq), .UPPER_PIN_GROUP_I(v[7:0]), .LOWPOWER_TIMER_OUT_I(v[9:8]),
    .PULSE_COUNTER_COMPARE_MATCH_I(v[12:10]), .PULSE_COUNTER_WRAP_I(v[15:13]),
    .PULSE_COUNTER_DIRECTION_I(v[18:16]), .CLOCK_OUTPUT_I(v[20:19]), .OPAMP_WARMED_I(v[23:21]),
    .OPAMP_VALID_I(v[26:24]), .OPAMP_STATUS_SELECT_I(opsel), .ULTRALOW_TIMER_PERIOD_I(v[27]),
    .DAC_CHANNEL_DONE_I(v[29:28]), .SERIAL_INFRARED_OUT_I(v[31:30]), .SERIAL_TRANSMIT_COMPLETE_I(v[35:32]),
    .SERIAL_RECEIVE_VALID_I(v[39:36]), .SERIAL_RTS_I(v[43:40]), .SERIAL_TX_I(v[47:44]),
    .SERIAL_CS_I(v[51:48]), .TIMER_UNDERFLOW_I(v[53:52]), .TIMER_OVERFLOW_I(v[55:54]),
    .TIMER_COMPARE_CAPTURE_I(v[63:56]), .WIDE_TIMER_UNDERFLOW_I(v[65:64]), .WIDE_TIMER_OVERFLOW_I(v[67:66]),
    .WIDE_TIMER_COMPARE_CAPTURE_I(v[75:68]), .CHANNEL_INPUT_O(ch_in), .CHANNEL_OUTPUT_O(ch_out));

  ////////////////////////////////////////
  task automatic print_verdict;
    if (fail_count == 0 && checks > 0) begin
      $display("Simulation passed");
    end else begin
      $display("Simulation failed");
    end
    $finish;
  endtask

  task automatic cmp(input logic [31:0] got, input logic [31:0] exp);
    checks++;
    if (got !== exp) begin
      fail_count++;
      $display("[ERR] t=%0t got=%h exp=%h", $time, got, exp);
    end
  endtask

  // One bus cycle: hold the request until waitrequest is seen low
  task automatic bus(input logic w, input logic [3:0] a, input logic [31:0] d, input logic [3:0] b,
                     output logic [31:0] q);
    int n;
    @(posedge clk);
    rd <= !w;
    wr <= w;
    addr <= a;
    wd <= d;
    be <= b;
    n = 0;
    do begin
      @(posedge clk);
      n++;
    end while (wreq !== 1'b0 && n < 20);
    q = rdata;
    rd <= 1'b0;
    wr <= 1'b0;
    if (n >= 20) begin
      fail_count++;
      print_verdict;
    end
  endtask

  task automatic wr32(input logic [3:0] a, input logic [31:0] d, input logic [3:0] b);
    logic [31:0] q;
    bus(1'b1, a, d, b, q);
  endtask

  task automatic rchk(input logic [3:0] a, input logic [31:0] exp);
    logic [31:0] q;
    bus(1'b0, a, 32'h0, 4'h0, q);
    cmp(q, exp);
  endtask

  task automatic drv(input logic [6:0] p, input logic i);
    @(posedge clk);
    pick <= p;
    inv <= i;
  endtask

  // Poll for a level, or with stay set require it on every cycle
  task automatic wait_lvl(input logic want, input logic stay);
    logic seen;
    seen = want;
    for (int n = 0; n < 16; n++) begin
      @(posedge clk);
      if (stay && ch_in !== want) seen = ch_in;
      if (!stay && ch_in === want) break;
    end
    if (!stay) seen = ch_in;
    cmp(32'(seen), 32'(want));
  endtask

  // Producer bit expected for a source and signal code, -1 when none
  function automatic int exp_idx(input logic [6:0] s, input int g, input logic [2:0] os);
    int n;
    int b;
    n = s[1:0];
    b = s[1] ? 64 : 52;
    case (s)
      7'h0d: return g;
      7'h0e: return g < 2 ? 8 + g : -1;
      7'h0f, 7'h10, 7'h11: return g < 3 ? 10 + 3 * g + int'(s) - 15 : -1;
      7'h12: return g < 2 ? 19 + g : -1;
      7'h18: return g < 2 ? 28 + g : (g < 5 ? (os[g - 2] ? 24 : 21) + g - 2 : -1);
      7'h1a: return g == 0 ? 27 : -1;
      7'h30, 7'h31, 7'h32, 7'h33: begin
        if (g == 0) return n == 0 ? 30 : (n == 2 ? 31 : -1);
        if (g == 4 || g == 7) return -1;
        return g < 4 ? 32 + 4 * (g - 1) + n : 44 + 4 * (g - 5) + n;
      end
      7'h3c, 7'h3d, 7'h3e, 7'h3f: begin
        n = s[0];
        if (g < 2) return b + 2 * g + n;
        return g - 2 < 3 + n ? b + 2 + 4 * n + g : -1;
      end
      default: return -1;
    endcase
  endfunction

  ////////////////////////////////////////
  // Reset values, lane writes, read-only and unmapped places
  task automatic t_regs;
    rchk(4'h0, 32'h0);
    rchk(4'h4, 32'h0);
    rchk(4'h8, 32'h0);
    wr32(4'h0, 32'hffff_ffff, 4'hf);
    rchk(4'h0, 32'h0030_7f07);
    wr32(4'h0, 32'h0, 4'h2);
    wr32(4'h4, 32'h0, 4'hf);
    wr32(4'h8, 32'h0, 4'hf);
    rchk(4'h0, 32'h0030_0007);
    rchk(4'h8, 32'h0);
  endtask

  // Every listed source with every signal code, both op-amp status choices
  task automatic t_map;
    int e;
    logic [6:0] srcs [18] = '{7'h00, 7'h0d, 7'h0e, 7'h0f, 7'h10, 7'h11, 7'h12, 7'h18, 7'h1a,
                              7'h30, 7'h31, 7'h32, 7'h33, 7'h3c, 7'h3d, 7'h3e, 7'h3f, 7'h13};
    for (int p = 0; p < 2; p++) begin
      @(posedge clk);
      opsel <= p ? 3'h7 : 3'h0;
      for (int i = 0; i < 18; i++) begin
        for (int g = 0; g < 8; g++) begin
          e = exp_idx(srcs[i], g, p ? 3'h7 : 3'h0);
          drv(7'h7f, 1'b0);
          wait_lvl(1'b0, 1'b0);
          wr32(4'h0, {17'h0, srcs[i], 5'h0, g[2:0]}, 4'hf);
          if (e < 0) begin
            drv(7'h7f, 1'b1);
            wait_lvl(1'b0, 1'b1);
          end else begin
            drv(e[6:0], 1'b0);
            wait_lvl(1'b1, 1'b0);
            drv(e[6:0], 1'b1);
            wait_lvl(1'b0, 1'b0);
          end
        end
      end
    end
  endtask

  // Count output pulses over an eight-cycle window
  task automatic cnt(output int c);
    c = 0;
    repeat (8) begin
      @(posedge clk);
      if (ch_out === 1'b1) c++;
    end
  endtask

  // All edge modes on a timer capture line, rise then fall
  task automatic t_edge;
    int c;
    for (int m = 0; m < 4; m++) begin
      drv(7'h7f, 1'b0);
      wr32(4'h0, {10'h0, m[1:0], 5'h0, 7'h3c, 5'h0, 3'h2}, 4'hf);
      drv(7'h38, 1'b0);
      cnt(c);
      if (m != 0) cmp(32'(c), 32'(m != 2));
      cmp(32'(ch_out), 32'(m == 0));
      if (m == 0) rchk(4'h4, 32'h3);
      drv(7'h7f, 1'b0);
      cnt(c);
      if (m != 0) cmp(32'(c), 32'(m >= 2));
      cmp(32'(ch_out), 32'h0);
    end
  endtask

  ////////////////////////////////////////
  initial begin
    repeat (4) @(posedge clk);
    rst_n <= 1'b1;
    t_regs;
    t_map;
    t_edge;
    @(posedge clk);
    rst_n <= 1'b0;
    @(posedge clk);
    rst_n <= 1'b1;
    rchk(4'h0, 32'h0);
    print_verdict;
  end
endmodule
